// [core/adc_control_register_decode.sv]
`timescale 1ns/10ps
`include "cfg_consts.svh"
// Notes on behaviour
// - 12-bit write-only register, loaded by chip-select and strobe
// - bits 11:10 choose power mode
// - bit 9: binary or twos complement coding
// - bit 8: one selects internal reference
// - bits 6:5 channel, or sequence end channel
// - bits 4:3 choose input arrangement
// - 00 single, 10 differential, 01 pseudo, 11 unused
// - bits 2:1 jointly form sequencer mode
// - 00 addressed channel, 11 scan 0 to end
// - bit 0: span one or two reference
// - 00 normal, 01 autoshutdown, 10 autostandby, 11 off
// - autoshutdown powers down after each conversion
// - autostandby keeps reference, wakes in 7us/600ns
// - full shutdown keeps configuration contents
// - all bits clear at power-up
module adc_control_register_decode #(
	parameter int WIDTH = `CFG_WIDTH
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic [WIDTH-1:0] db,
	input wire logic conv_start,
	input wire logic conv_done,
	output logic [1:0] power_mode,
	output logic coding_twos,
	output logic ref_internal,
	output logic [1:0] channel_sel,
	output logic [1:0] input_config,
	output logic [1:0] auto_scan_ctl,
	output logic span_double,
	output logic input_config_bad,
	output logic scan_ctl_bad,
	output logic zero_bit_bad,
	output logic [1:0] conv_channel,
	output logic [1:0] conv_neg_channel,
	output logic neg_is_ground,
	output logic core_powered,
	output logic ref_powered,
	output logic ref_buf_partial,
	output logic ready
);
	localparam int WAKE_INT_CYC = (`WAKE_INT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int WAKE_EXT_CYC = (`WAKE_EXT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int WCW = $clog2(WAKE_INT_CYC + 1);

	function automatic logic [1:0] pair_partner(input logic [1:0] ch);
		pair_partner = {ch[1], ~ch[0]};
	endfunction

	// pins are asynchronous to ref_clk: two flops before use
	logic cs_n_s1, cs_n_s2, wr_n_s1, wr_n_s2, wr_n_s3;
	logic [WIDTH-1:0] db_s1, db_s2;
	logic wr_en;
	logic [WIDTH-1:0] cfg;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cs_n_s1 <= 1'b1;
			cs_n_s2 <= 1'b1;
			wr_n_s1 <= 1'b1;
			wr_n_s2 <= 1'b1;
			wr_n_s3 <= 1'b1;
			db_s1 <= '0;
			db_s2 <= '0;
		end else begin
			cs_n_s1 <= cs_n;
			cs_n_s2 <= cs_n_s1;
			wr_n_s1 <= wr_n;
			wr_n_s2 <= wr_n_s1;
			wr_n_s3 <= wr_n_s2;
			db_s1 <= db;
			db_s2 <= db_s1;
		end
	end

	// data passes the same two stages, so it lines up with the edge
	assign wr_en = ~cs_n_s2 & ~wr_n_s3 & wr_n_s2;

	cfg_store #(.WIDTH(WIDTH)) u_store (
		.ref_clk(ref_clk),
		.rst(rst),
		.wr_en(wr_en),
		.wr_data(db_s2),
		.q(cfg)
	);

	// field decode, registered so outputs come straight from flops
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			power_mode <= 2'b00;
			coding_twos <= 1'b0;
			ref_internal <= 1'b0;
			channel_sel <= 2'b00;
			input_config <= 2'b00;
			auto_scan_ctl <= 2'b00;
			span_double <= 1'b0;
			input_config_bad <= 1'b0;
			scan_ctl_bad <= 1'b0;
			zero_bit_bad <= 1'b0;
		end else begin
			power_mode <= {cfg[`CFG_PM_HI], cfg[`CFG_PM_LO]};
			coding_twos <= cfg[`CFG_CODING];
			ref_internal <= cfg[`CFG_REFSEL];
			channel_sel <= {cfg[`CFG_CH_HI], cfg[`CFG_CH_LO]};
			input_config <= {cfg[`CFG_IN_HI], cfg[`CFG_IN_LO]};
			auto_scan_ctl <= {cfg[`CFG_SEQ_HI], cfg[`CFG_SEQ_LO]};
			span_double <= cfg[`CFG_SPAN];
			input_config_bad <= cfg[`CFG_IN_HI] & cfg[`CFG_IN_LO];
			scan_ctl_bad <= cfg[`CFG_SEQ_HI] ^ cfg[`CFG_SEQ_LO];
			// flag only; the bit is stored and otherwise ignored
			zero_bit_bad <= cfg[`CFG_ZERO];
		end
	end

	// channel for the next conversion, stepping in scan mode
	logic [1:0] seq_ch_reg;
	logic scan_on;
	logic [1:0] last_ch;
	logic [1:0] next_ch;
	assign scan_on = cfg[`CFG_SEQ_HI] & cfg[`CFG_SEQ_LO];
	assign last_ch = {cfg[`CFG_CH_HI], cfg[`CFG_CH_LO]};

	always_comb begin
		if (!scan_on) begin
			next_ch = last_ch;
		end else if (cfg[`CFG_IN_HI] ^ cfg[`CFG_IN_LO]) begin
			// paired inputs: inverse channels are skipped
			next_ch = (seq_ch_reg >= {last_ch[1], 1'b0}) ? 2'b00 : seq_ch_reg + 2'b10;
		end else begin
			next_ch = (seq_ch_reg >= last_ch) ? 2'b00 : seq_ch_reg + 2'b01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || wr_en) begin
			seq_ch_reg <= 2'b00;
		end else if (conv_done && scan_on) begin
			seq_ch_reg <= next_ch;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			conv_channel <= 2'b00;
			conv_neg_channel <= 2'b00;
			neg_is_ground <= 1'b1;
		end else begin
			conv_channel <= scan_on ? seq_ch_reg : last_ch;
			conv_neg_channel <= pair_partner(scan_on ? seq_ch_reg : last_ch);
			neg_is_ground <= ~(cfg[`CFG_IN_HI] ^ cfg[`CFG_IN_LO]);
		end
	end

	// power sequencing
	cfg_pkg::pwr_state_t st_reg, st_next;
	cfg_pkg::power_mode_t pm;
	logic [WCW-1:0] wake_reg;
	logic wake_done;
	assign pm = cfg_pkg::power_mode_t'({cfg[`CFG_PM_HI], cfg[`CFG_PM_LO]});
	assign wake_done = (wake_reg == '0);

	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			cfg_pkg::PWR_ON: begin
				if (pm == cfg_pkg::PM_FULL_SHUTDOWN) begin
					st_next = cfg_pkg::PWR_OFF;
				end else if (conv_done && pm == cfg_pkg::PM_AUTO_SHUTDOWN) begin
					st_next = cfg_pkg::PWR_OFF;
				end else if (conv_done && pm == cfg_pkg::PM_AUTO_STANDBY) begin
					st_next = cfg_pkg::PWR_STANDBY;
				end
			end
			cfg_pkg::PWR_STANDBY, cfg_pkg::PWR_OFF: begin
				if (pm == cfg_pkg::PM_FULL_SHUTDOWN) begin
					// standby must not keep the reference up once full shutdown is asked
					st_next = cfg_pkg::PWR_OFF;
				end else if (pm == cfg_pkg::PM_NORMAL || conv_start) begin
					st_next = cfg_pkg::PWR_WAKE;
				end
			end
			cfg_pkg::PWR_WAKE: begin
				if (pm == cfg_pkg::PM_FULL_SHUTDOWN) begin
					st_next = cfg_pkg::PWR_OFF;
				end else if (wake_done) begin
					st_next = cfg_pkg::PWR_ON;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_reg <= cfg_pkg::PWR_ON;
		end else begin
			st_reg <= st_next;
		end
	end

	// wake delay from standby depends on reference source
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wake_reg <= '0;
		end else if (st_reg != cfg_pkg::PWR_WAKE && st_next == cfg_pkg::PWR_WAKE) begin
			if (st_reg == cfg_pkg::PWR_STANDBY && !cfg[`CFG_REFSEL]) begin
				wake_reg <= WCW'(WAKE_EXT_CYC - 1);
			end else begin
				wake_reg <= WCW'(WAKE_INT_CYC - 1);
			end
		end else if (!wake_done) begin
			wake_reg <= wake_reg - 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			core_powered <= 1'b1;
			ref_powered <= 1'b1;
			ref_buf_partial <= 1'b0;
			ready <= 1'b1;
		end else begin
			core_powered <= (st_next == cfg_pkg::PWR_ON) || (st_next == cfg_pkg::PWR_WAKE);
			ref_powered <= (st_next != cfg_pkg::PWR_OFF);
			ref_buf_partial <= (st_next == cfg_pkg::PWR_STANDBY);
			ready <= (st_next == cfg_pkg::PWR_ON);
		end
	end
endmodule

// [core/cfg_consts.svh]
`ifndef CFG_CONSTS_SVH
`define CFG_CONSTS_SVH
`define CFG_WIDTH 12
`define CFG_RESET 12'h000
`define CFG_PM_HI 11
`define CFG_PM_LO 10
`define CFG_CODING 9
`define CFG_REFSEL 8
`define CFG_ZERO 7
`define CFG_CH_HI 6
`define CFG_CH_LO 5
`define CFG_IN_HI 4
`define CFG_IN_LO 3
`define CFG_SEQ_HI 2
`define CFG_SEQ_LO 1
`define CFG_SPAN 0
`define WAKE_INT_NS 7000
`define WAKE_EXT_NS 600
`define CLK_PERIOD_NS 20
`endif

// [core/cfg_pkg.sv]
package cfg_pkg;
	typedef enum logic [1:0] {
		PM_NORMAL = 2'b00,
		PM_AUTO_SHUTDOWN = 2'b01,
		PM_AUTO_STANDBY = 2'b10,
		PM_FULL_SHUTDOWN = 2'b11
	} power_mode_t;
	typedef enum logic [1:0] {
		IN_SINGLE = 2'b00,
		IN_PSEUDO = 2'b01,
		IN_DIFF = 2'b10,
		IN_UNUSED = 2'b11
	} input_cfg_t;
	typedef enum logic [1:0] {
		PWR_ON = 2'b00,
		PWR_STANDBY = 2'b01,
		PWR_OFF = 2'b10,
		PWR_WAKE = 2'b11
	} pwr_state_t;
endpackage

// [core/cfg_store.sv]
`timescale 1ns/10ps
`include "cfg_consts.svh"
// configuration storage; write-only, so no read path exists
module cfg_store #(
	parameter int WIDTH = `CFG_WIDTH
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	output logic [WIDTH-1:0] q
);
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= WIDTH'(`CFG_RESET);
		end else if (wr_en) begin
			q <= wr_data;
		end
	end
endmodule

// [sim/adc_cfg_assertions.sv]
`timescale 1ns/10ps
module adc_cfg_checker (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wr_n,
	input wire logic conv_start,
	input wire logic conv_done,
	input wire logic [1:0] power_mode,
	input wire logic [1:0] input_config,
	input wire logic [1:0] auto_scan_ctl,
	input wire logic input_config_bad,
	input wire logic scan_ctl_bad,
	input wire logic core_powered,
	input wire logic ref_powered,
	input wire logic ref_buf_partial,
	input wire logic ready
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_done(m);
		ready && power_mode == m && conv_done;
	endsequence
	a_fields_hold: assert property (wr_n[*8] |-> $stable(power_mode) && $stable(input_config))
		else $error("field moved without a write");
	a_input_bad: assert property (input_config_bad == (input_config == 2'b11))
		else $error("input flag wrong");
	a_scan_bad: assert property (scan_ctl_bad == (auto_scan_ctl inside {2'b01, 2'b10}))
		else $error("scan flag wrong");
	a_ready_full: assert property (ready |-> core_powered && ref_powered && !ref_buf_partial)
		else $error("ready while not powered");
	a_off_held: assert property (power_mode == 2'b11 [*2] |-> !core_powered && !ref_powered)
		else $error("powered in full shutdown");
	a_auto_off: assert property (s_done(2'b01) |=> !core_powered && !ref_powered)
		else $error("no shutdown after conversion");
	a_standby_ref: assert property (s_done(2'b10) |=> ref_powered && ref_buf_partial && !core_powered)
		else $error("standby levels wrong");
	sequence s_wake_req;
		!core_powered && conv_start && power_mode inside {2'b01, 2'b10};
	endsequence
	a_wake_bound: assert property (s_wake_req |-> ##[1:360] ready)
		else $error("wake too slow");
endmodule
bind adc_control_register_decode adc_cfg_checker adc_cfg_checker_inst (.ref_clk, .rst, .wr_n,
	.conv_start, .conv_done, .power_mode, .input_config, .auto_scan_ctl, .input_config_bad,
	.scan_ctl_bad, .core_powered, .ref_powered, .ref_buf_partial, .ready);

// [sim/adc_control_register_decode_bench.sv]
`timescale 1ns/10ps
`include "cfg_consts.svh"
module adc_control_register_decode_bench;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic conv_start = 1'b0;
	logic conv_done = 1'b0;
	logic cs_n, wr_n, coding_twos, ref_internal, span_double, zero_bit_bad, input_config_bad;
	logic scan_ctl_bad, neg_is_ground, core_powered, ref_powered, ref_buf_partial, ready;
	logic [11:0] db;
	logic [1:0] power_mode, channel_sel, input_config, auto_scan_ctl, conv_channel, conv_neg_channel;
	logic [11:0] pm_tab[3] = '{12'h400, 12'h900, 12'hA00};
	// single-ended scan to 3, pseudo pairs to 3, full pairs to 2
	logic [11:0] scan_tab[3] = '{12'h066, 12'h06E, 12'h056};
	int n_fail = 0;
	int check_count = 0;
	int cfg_q[$] = {0};
	int n, m, lst, stp;
	always #10 ref_clk = ~ref_clk;
	host_writer host_inst (.ref_clk, .cs_n, .wr_n, .db);
	adc_control_register_decode adc_control_register_decode_inst (.ref_clk, .rst, .cs_n, .wr_n,
		.db, .conv_start, .conv_done, .power_mode, .coding_twos, .ref_internal, .channel_sel,
		.input_config, .auto_scan_ctl, .span_double, .input_config_bad, .scan_ctl_bad,
		.zero_bit_bad, .conv_channel, .conv_neg_channel, .neg_is_ground, .core_powered,
		.ref_powered, .ref_buf_partial, .ready);
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// unselected strobes leave the model untouched
	task automatic wr(input logic sel, input logic [11:0] v);
		int c, ic, sq, ch;
		logic [11:0] got;
		logic [2:0] exp3;
		host_inst.write(sel, v);
		if (sel) cfg_q.push_back(v);
		c = cfg_q[$];
		ic = (c >> 3) & 3;
		sq = (c >> 1) & 3;
		// a scan restarts from channel 0 after every write
		ch = (sq == 3) ? 0 : (c >> 5) & 3;
		got = {power_mode, coding_twos, ref_internal, zero_bit_bad, channel_sel, input_config,
			auto_scan_ctl, span_double};
		exp3 = {ic == 3, sq == 1 || sq == 2, ic == 0 || ic == 3};
		chk(got, 12'(c));
		chk(12'({input_config_bad, scan_ctl_bad, neg_is_ground}), 12'(exp3));
		chk(12'(conv_channel), 12'(ch));
		chk(12'(conv_neg_channel), 12'(ch ^ 1));
	endtask
	task automatic pulse(input bit done);
		@(negedge ref_clk);
		if (done) conv_done = 1'b1;
		else conv_start = 1'b1;
		@(negedge ref_clk);
		conv_done = 1'b0;
		conv_start = 1'b0;
	endtask
	task automatic wait_ready;
		n = 0;
		while (ready !== 1'b1 && n < 1000) begin
			@(negedge ref_clk);
			n++;
		end
		chk(12'(ready), 12'h001);
	endtask
	initial begin
		void'($urandom(32'h379f));
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		chk({core_powered, ref_powered, ready, ref_buf_partial, neg_is_ground}, 12'h1D);
		wr(1'b0, 12'hFFF);
		$display("test reset done");
		repeat (16) wr($urandom % 4 != 0, $urandom & 12'hF7F);
		wr(1'b1, 12'hC80);
		chk({core_powered, ref_powered, ready}, 12'h0);
		$display("test random and shutdown done");
		foreach (pm_tab[i]) begin
			wr(1'b1, 12'h000);
			wait_ready();
			wr(1'b1, pm_tab[i]);
			pulse(1'b1);
			chk({core_powered, ref_powered, ref_buf_partial}, pm_tab[i][11] ? 12'h3 : 12'h0);
			pulse(1'b0);
			wait_ready();
			m = (pm_tab[i] == 12'hA00 ? `WAKE_EXT_NS : `WAKE_INT_NS) / `CLK_PERIOD_NS;
			chk(12'(n > m - 3 && n < m + 3), 12'h1);
		end
		$display("test power modes done");
		pulse(1'b1);
		wr(1'b1, 12'hC00);
		chk(12'({core_powered, ref_powered, ready}), 12'h000);
		$display("test shutdown from standby done");
		foreach (scan_tab[i]) begin
			wr(1'b1, scan_tab[i]);
			lst = (scan_tab[i] >> 5) & 3;
			stp = (((scan_tab[i] >> 3) & 3) inside {1, 2}) ? 2 : 1;
			m = 0;
			repeat (5) begin
				pulse(1'b1);
				// channel output follows the pointer one edge later
				@(negedge ref_clk);
				m = (m + stp > lst) ? 0 : m + stp;
				chk(12'(conv_channel), 12'(m));
				chk(12'(conv_neg_channel), 12'(m ^ 1));
			end
		end
		$display("test scan done");
		rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		cfg_q.push_back(0);
		chk(12'({core_powered, ref_powered, ready, ref_buf_partial, neg_is_ground}), 12'h01D);
		wr(1'b0, 12'hFFF);
		$display("test mid-run reset done");
		conclude();
	end
	initial begin
		#(20 * 30000);
		n_fail++;
		conclude();
	end
endmodule

// [sim/host_writer.sv]
`timescale 1ns/10ps
// host side of the pin-written register; drives only at falling edges
module host_writer (
	input wire logic ref_clk,
	output logic cs_n,
	output logic wr_n,
	output logic [11:0] db
);
	initial begin
		cs_n = 1'b1;
		wr_n = 1'b1;
		db = 12'h000;
	end
	// data held 3 cycles past the strobe rise, then inverted so stale data never looks valid
	task automatic write(input logic sel, input logic [11:0] v);
		@(negedge ref_clk);
		cs_n = !sel;
		wr_n = 1'b0;
		db = v;
		repeat (3) @(negedge ref_clk);
		wr_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		cs_n = 1'b1;
		db = ~v;
		repeat (6) @(negedge ref_clk);
	endtask
endmodule
